// ---- hw/stw_divider.sv ----
/*
 * stw_divider: reloadable down counter giving one tick every div_i+1
 * enabled cycles.
 * assumes: en_i is a level or a one-cycle enable from the previous stage.
 */
`timescale 1ns/1ps
module stw_divider #(
	parameter int W = 16
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// control
	input wire logic en_i,
	input wire logic load_i,
	input wire logic [W-1:0] div_i,
	// output
	output logic tick_o
);
	logic [W-1:0] cnt;
	wire term = (cnt == '0);

	// reload on terminal count makes a new divisor take effect at expiry
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cnt <= '0;
			tick_o <= 1'b0;
		end else begin
			tick_o <= en_i & term & ~load_i;
			if (load_i)
				cnt <= div_i;
			else if (en_i)
				cnt <= term ? div_i : cnt - 1'b1;
		end
	end

endmodule : stw_divider

// ---- hw/stw_pkg.sv ----
/*
 * stw_pkg: register map, field positions, reset values, stage indices and
 * carrier types for the system timebase and watchdog block.
 * assumes: one 4 MHz system clock; the core reaches registers by an 8-bit
 * special function register address.
 */
package stw_pkg;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_ACLK = 8'hf6;
	localparam logic [7:0] ADDR_SOFT_RESET_REQUEST = 8'hf7;
	localparam logic [7:0] ADDR_PRIO = 8'hf8;
	localparam logic [7:0] ADDR_SLOW = 8'hf9;
	localparam logic [7:0] ADDR_FAST = 8'hfa;
	localparam logic [7:0] ADDR_MICRO_TICK_DIVIDER = 8'hfb;
	localparam logic [7:0] ADDR_PSCL = 8'hfc;
	localparam logic [7:0] ADDR_PSCH = 8'hfd;
	localparam logic [7:0] ADDR_DECI = 8'hfe;
	localparam logic [7:0] ADDR_WDOG = 8'hff;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [6:0] RST_ACLK = 7'h03;
	localparam logic [4:0] RST_PRIO = 5'h00;
	localparam logic [7:0] PRIO_FIXED_ONES = 8'he0;
	localparam logic [6:0] RST_SLOW = 7'h7f;
	localparam logic [6:0] RST_FAST = 7'h7f;
	localparam logic [5:0] RST_MICRO_TICK_DIVIDER = 6'h03;
	localparam logic [7:0] RST_PSCL = 8'h9f;
	localparam logic [7:0] RST_PSCH = 8'h0f;
	localparam logic [7:0] RST_DECI = 8'h63;
	localparam logic [7:0] RST_WDOG = 8'h00;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int RESET_REQUEST_BIT = 0;
	localparam int LOAD_IMMEDIATELY = 7;
	localparam int WATCHDOG_ENABLE_BIT = 7;
	localparam int WATCHDOG_DISABLE_BIT = 6;
	localparam int WATCHDOG_RESTART_BIT = 5;
	localparam int WATCHDOG_IRQ_PRIORITY = 4;

	// modulator clock is the adc clock divided by 64
	localparam logic [15:0] MOD_DIV_M1 = 16'h003f;

	// ----------------------------------------------------------------
	// divider stage indices
	// ----------------------------------------------------------------
	localparam int DIV_W = 16;
	localparam int N_STAGE = 7;
	localparam int ST_MICRO_TICK_DIVIDER = 0;
	localparam int ST_TICK_PRESCALE = 1;
	localparam int ST_DECI = 2;
	localparam int ST_SLOW = 3;
	localparam int ST_FAST = 4;
	localparam int ST_ADC = 5;
	localparam int ST_MOD = 6;

	// ----------------------------------------------------------------
	// carrier types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic watchdog_irq_priority;
		logic ext_irq5_priority;
		logic ext_irq4_priority;
		logic ext_irq3_priority;
		logic ext_irq2_priority;
	} stw_prio_t;

	typedef struct packed {
		logic micro_tick_divider;
		logic tick_prescale;
		logic deci;
		logic adc;
		logic modulator;
	} stw_ticks_t;

	typedef enum logic [1:0] {
		WD_OFF = 2'b01,
		WD_RUN = 2'b10
	} stw_wd_state_t;

endpackage : stw_pkg

// ---- hw/stw_timebase.sv ----
/*
 * stw_timebase: divider chain, interval timers, watchdog, adc clock,
 * soft reset request and interrupt priority bits.
 * assumes: single-cycle register reads and writes from the core; power-down
 * and watchdog reset enable bits arrive as levels from elsewhere.
 */
// Behaviour
// - adc enable every aclk divisor+1 clocks; modulator every 64 adc enables.
// - writing one then zero to the reset request bit pulses system reset.
// - watchdog priority bit: one high, zero low priority.
// - bits 3..0 give ext irq 5..2 priority; top three bits read one.
// - slow timer interrupt every (count+1)(deci+1)(prescale+1) clocks.
// - reading the slow timer register clears its pending interrupt.
// - slow timer load delayed or immediate by bit 7; bit 7 reads zero.
// - fast timer interrupt every (count+1)(prescale+1) clocks, 7-bit count.
// - fast timer load delayed or immediate by bit 7; bit 7 reads zero.
// - microsecond tick every micro divisor+1 clocks, for flash write timing.
// - millisecond tick every high*256+low+1 clocks, for flash erase timing.
// - decitick every decitick divisor+1 millisecond ticks.
// - one-then-zero on enable bit sets watchdog counting state.
// - one-then-zero on disable bit clears watchdog counting state.
// - one-then-zero on restart bit reloads watchdog counter.
// - watchdog expires after count+1 to count+2 deciticks.
// - expiry gives system reset if reset enable set, else interrupt.
// - slow timer pending status is offered for the aux status register.
// - timebase power-down stops all timebase counting but the adc and modulator clocks; set after reset.
// - watchdog power-down holds watchdog off; set after reset.
`timescale 1ns/1ps
module stw_timebase (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// register access
	input wire logic [7:0] sfr_addr_i,
	input wire logic sfr_wr_i,
	input wire logic sfr_rd_i,
	input wire logic [7:0] sfr_wdata_i,
	output logic [7:0] sfr_rdata_o,
	// configuration levels
	input wire logic timebase_power_down_i,
	input wire logic watchdog_power_down_i,
	input wire logic watchdog_reset_enable_i,
	// ticks and clock enables
	output stw_pkg::stw_ticks_t ticks_o,
	// interrupts and reset
	output logic slow_irq_o,
	output logic fast_irq_o,
	output logic watchdog_irq_o,
	output logic sys_reset_o,
	// priorities
	output stw_pkg::stw_prio_t prio_o
);

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [6:0] adc_clock_divisor;
	logic reset_request_bit;
	logic [6:0] whole_interval_count;
	logic [6:0] millisecond_count;
	logic [5:0] micro_tick_divisor;
	logic [7:0] tick_prescale_low_field;
	logic [7:0] tick_prescale_high_field;
	logic [7:0] decitick_divisor;
	logic [7:0] watchdog_control;
	logic [5:0] wd_cnt;
	stw_pkg::stw_wd_state_t wd_state;
	stw_pkg::stw_wd_state_t next_wd_state;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire wr_aclk = sfr_wr_i & (sfr_addr_i == stw_pkg::ADDR_ACLK);
	wire wr_soft_reset_request = sfr_wr_i & (sfr_addr_i == stw_pkg::ADDR_SOFT_RESET_REQUEST);
	wire wr_prio = sfr_wr_i & (sfr_addr_i == stw_pkg::ADDR_PRIO);
	wire wr_slow = sfr_wr_i & (sfr_addr_i == stw_pkg::ADDR_SLOW);
	wire wr_fast = sfr_wr_i & (sfr_addr_i == stw_pkg::ADDR_FAST);
	wire wr_micro_tick_divider = sfr_wr_i & (sfr_addr_i == stw_pkg::ADDR_MICRO_TICK_DIVIDER);
	wire wr_pscl = sfr_wr_i & (sfr_addr_i == stw_pkg::ADDR_PSCL);
	wire wr_psch = sfr_wr_i & (sfr_addr_i == stw_pkg::ADDR_PSCH);
	wire wr_deci = sfr_wr_i & (sfr_addr_i == stw_pkg::ADDR_DECI);
	wire wr_wdog = sfr_wr_i & (sfr_addr_i == stw_pkg::ADDR_WDOG);
	wire rd_slow = sfr_rd_i & (sfr_addr_i == stw_pkg::ADDR_SLOW);
	wire rd_fast = sfr_rd_i & (sfr_addr_i == stw_pkg::ADDR_FAST);
	wire load_now = sfr_wdata_i[stw_pkg::LOAD_IMMEDIATELY];

	// falling edge of a stored bit caused by a write
	wire soft_reset_request_fall = wr_soft_reset_request & reset_request_bit
		& ~sfr_wdata_i[stw_pkg::RESET_REQUEST_BIT];
	wire wd_en_fall = wr_wdog & watchdog_control[stw_pkg::WATCHDOG_ENABLE_BIT]
		& ~sfr_wdata_i[stw_pkg::WATCHDOG_ENABLE_BIT];
	wire wd_dis_fall = wr_wdog & watchdog_control[stw_pkg::WATCHDOG_DISABLE_BIT]
		& ~sfr_wdata_i[stw_pkg::WATCHDOG_DISABLE_BIT];
	wire wd_rst_fall = wr_wdog & watchdog_control[stw_pkg::WATCHDOG_RESTART_BIT]
		& ~sfr_wdata_i[stw_pkg::WATCHDOG_RESTART_BIT];

	// ----------------------------------------------------------------
	// divider chain
	// ----------------------------------------------------------------
	logic [stw_pkg::N_STAGE-1:0] st_en;
	logic [stw_pkg::N_STAGE-1:0] st_ld;
	logic [stw_pkg::N_STAGE-1:0] st_tick;
	logic [stw_pkg::DIV_W-1:0] st_div [stw_pkg::N_STAGE];

	wire tb_run = ~timebase_power_down_i;

	assign st_en[stw_pkg::ST_MICRO_TICK_DIVIDER] = tb_run;
	assign st_en[stw_pkg::ST_TICK_PRESCALE] = tb_run;
	assign st_en[stw_pkg::ST_DECI] = tb_run & st_tick[stw_pkg::ST_TICK_PRESCALE];
	assign st_en[stw_pkg::ST_SLOW] = tb_run & st_tick[stw_pkg::ST_DECI];
	assign st_en[stw_pkg::ST_FAST] = tb_run & st_tick[stw_pkg::ST_TICK_PRESCALE];
	// adc clock belongs to the adc, not to the system timer power domain
	assign st_en[stw_pkg::ST_ADC] = 1'b1;
	assign st_en[stw_pkg::ST_MOD] = st_tick[stw_pkg::ST_ADC];

	assign st_div[stw_pkg::ST_MICRO_TICK_DIVIDER] = {10'h000, micro_tick_divisor};
	assign st_div[stw_pkg::ST_TICK_PRESCALE] = {tick_prescale_high_field, tick_prescale_low_field};
	assign st_div[stw_pkg::ST_DECI] = {8'h00, decitick_divisor};
	assign st_div[stw_pkg::ST_SLOW] = {9'h000, whole_interval_count};
	assign st_div[stw_pkg::ST_FAST] = {9'h000, millisecond_count};
	assign st_div[stw_pkg::ST_ADC] = {9'h000, adc_clock_divisor};
	assign st_div[stw_pkg::ST_MOD] = stw_pkg::MOD_DIV_M1;

	// immediate load restarts the interval; delayed load waits for expiry
	assign st_ld[stw_pkg::ST_MICRO_TICK_DIVIDER] = 1'b0;
	assign st_ld[stw_pkg::ST_TICK_PRESCALE] = 1'b0;
	assign st_ld[stw_pkg::ST_DECI] = 1'b0;
	assign st_ld[stw_pkg::ST_SLOW] = wr_slow & load_now;
	assign st_ld[stw_pkg::ST_FAST] = wr_fast & load_now;
	assign st_ld[stw_pkg::ST_ADC] = 1'b0;
	assign st_ld[stw_pkg::ST_MOD] = 1'b0;

	// ----------------------------------------------------------------
	// divider instances
	// ----------------------------------------------------------------
	// the immediate load takes the written value: the counter register
	// updates in the same cycle, so the next cycle reloads it correctly
	logic [stw_pkg::DIV_W-1:0] st_ld_div [stw_pkg::N_STAGE];
	assign st_ld_div[stw_pkg::ST_MICRO_TICK_DIVIDER] = st_div[stw_pkg::ST_MICRO_TICK_DIVIDER];
	assign st_ld_div[stw_pkg::ST_TICK_PRESCALE] = st_div[stw_pkg::ST_TICK_PRESCALE];
	assign st_ld_div[stw_pkg::ST_DECI] = st_div[stw_pkg::ST_DECI];
	assign st_ld_div[stw_pkg::ST_SLOW] = {9'h000, sfr_wdata_i[6:0]};
	assign st_ld_div[stw_pkg::ST_FAST] = {9'h000, sfr_wdata_i[6:0]};
	assign st_ld_div[stw_pkg::ST_ADC] = st_div[stw_pkg::ST_ADC];
	assign st_ld_div[stw_pkg::ST_MOD] = st_div[stw_pkg::ST_MOD];

	genvar gi;
	generate
		for (gi = 0; gi < stw_pkg::N_STAGE; gi++) begin : g_stage
			stw_divider #(
				.W(stw_pkg::DIV_W)
			) u_div (
				.clk_i(clk_i),
				.sys_rst_i(sys_rst_i),
				.en_i(st_en[gi]),
				.load_i(st_ld[gi]),
				.div_i(st_ld[gi] ? st_ld_div[gi] : st_div[gi]),
				.tick_o(st_tick[gi])
			);
		end
	endgenerate

	assign ticks_o.micro_tick_divider = st_tick[stw_pkg::ST_MICRO_TICK_DIVIDER];
	assign ticks_o.tick_prescale = st_tick[stw_pkg::ST_TICK_PRESCALE];
	assign ticks_o.deci = st_tick[stw_pkg::ST_DECI];
	assign ticks_o.adc = st_tick[stw_pkg::ST_ADC];
	assign ticks_o.modulator = st_tick[stw_pkg::ST_MOD];

	// ----------------------------------------------------------------
	// watchdog
	// ----------------------------------------------------------------
	wire wd_tick = st_tick[stw_pkg::ST_DECI];
	wire wd_live = (wd_state == stw_pkg::WD_RUN);
	wire wd_expire = wd_live & wd_tick & (wd_cnt == 6'h00);
	// a software start lands mid-interval, so it adds one whole tick on top
	wire wd_extra = wd_rst_fall | wd_en_fall;
	wire wd_reload = wd_extra | wd_expire;

	always_comb begin
		case (wd_state)
			stw_pkg::WD_OFF: next_wd_state = wd_en_fall ? stw_pkg::WD_RUN : stw_pkg::WD_OFF;
			stw_pkg::WD_RUN: next_wd_state = wd_dis_fall ? stw_pkg::WD_OFF : stw_pkg::WD_RUN;
			default: next_wd_state = stw_pkg::WD_OFF;
		endcase
		// power-down overrides software enable
		if (watchdog_power_down_i)
			next_wd_state = stw_pkg::WD_OFF;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wd_state <= stw_pkg::WD_OFF;
			wd_cnt <= 6'h00;
		end else begin
			wd_state <= next_wd_state;
			if (wd_reload)
				wd_cnt <= {1'b0, watchdog_control[4:0]} + {5'h00, wd_extra};
			else if (wd_live & wd_tick)
				wd_cnt <= wd_cnt - 6'h01;
		end
	end

	// ----------------------------------------------------------------
	// register writes
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			adc_clock_divisor <= stw_pkg::RST_ACLK;
			reset_request_bit <= 1'b0;
			prio_o <= stw_pkg::RST_PRIO;
			whole_interval_count <= stw_pkg::RST_SLOW;
			millisecond_count <= stw_pkg::RST_FAST;
			micro_tick_divisor <= stw_pkg::RST_MICRO_TICK_DIVIDER;
			tick_prescale_low_field <= stw_pkg::RST_PSCL;
			tick_prescale_high_field <= stw_pkg::RST_PSCH;
			decitick_divisor <= stw_pkg::RST_DECI;
			watchdog_control <= stw_pkg::RST_WDOG;
		end else begin
			if (wr_aclk)
				adc_clock_divisor <= sfr_wdata_i[6:0];
			if (wr_soft_reset_request)
				reset_request_bit <= sfr_wdata_i[stw_pkg::RESET_REQUEST_BIT];
			if (wr_prio)
				prio_o <= sfr_wdata_i[4:0];
			if (wr_slow)
				whole_interval_count <= sfr_wdata_i[6:0];
			if (wr_fast)
				millisecond_count <= sfr_wdata_i[6:0];
			if (wr_micro_tick_divider)
				micro_tick_divisor <= sfr_wdata_i[5:0];
			if (wr_pscl)
				tick_prescale_low_field <= sfr_wdata_i;
			if (wr_psch)
				tick_prescale_high_field <= sfr_wdata_i;
			if (wr_deci)
				decitick_divisor <= sfr_wdata_i;
			if (wr_wdog)
				watchdog_control <= sfr_wdata_i;
		end
	end

	// ----------------------------------------------------------------
	// interrupts and reset
	// ----------------------------------------------------------------
	// a tick in the cycle of the clearing read keeps the flag set
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			slow_irq_o <= 1'b0;
			fast_irq_o <= 1'b0;
			watchdog_irq_o <= 1'b0;
			sys_reset_o <= 1'b0;
		end else begin
			slow_irq_o <= st_tick[stw_pkg::ST_SLOW] | (slow_irq_o & ~rd_slow);
			fast_irq_o <= st_tick[stw_pkg::ST_FAST] | (fast_irq_o & ~rd_fast);
			watchdog_irq_o <= wd_expire & ~watchdog_reset_enable_i;
			sys_reset_o <= soft_reset_request_fall | (wd_expire & watchdog_reset_enable_i);
		end
	end

	// ----------------------------------------------------------------
	// register reads
	// ----------------------------------------------------------------
	wire [7:0] rd_mux =
		(sfr_addr_i == stw_pkg::ADDR_ACLK) ? {1'b0, adc_clock_divisor} :
		(sfr_addr_i == stw_pkg::ADDR_SOFT_RESET_REQUEST) ? {7'h00, reset_request_bit} :
		(sfr_addr_i == stw_pkg::ADDR_PRIO) ? (stw_pkg::PRIO_FIXED_ONES | {3'h0, prio_o}) :
		(sfr_addr_i == stw_pkg::ADDR_SLOW) ? {1'b0, whole_interval_count} :
		(sfr_addr_i == stw_pkg::ADDR_FAST) ? {1'b0, millisecond_count} :
		(sfr_addr_i == stw_pkg::ADDR_MICRO_TICK_DIVIDER) ? {2'h0, micro_tick_divisor} :
		(sfr_addr_i == stw_pkg::ADDR_PSCL) ? tick_prescale_low_field :
		(sfr_addr_i == stw_pkg::ADDR_PSCH) ? tick_prescale_high_field :
		(sfr_addr_i == stw_pkg::ADDR_DECI) ? decitick_divisor :
		(sfr_addr_i == stw_pkg::ADDR_WDOG) ? watchdog_control : 8'h00;

	always_ff @(posedge clk_i) begin
		if (sys_rst_i)
			sfr_rdata_o <= 8'h00;
		else if (sfr_rd_i)
			sfr_rdata_o <= rd_mux;
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// cycles since the last microsecond tick, for the period check
	logic [7:0] micro_tick_divider_gap;
	// first tick after power-up comes from a held counter, so skip it
	logic micro_tick_divider_seen;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i | ~tb_run)
			micro_tick_divider_seen <= 1'b0;
		else if (st_tick[stw_pkg::ST_MICRO_TICK_DIVIDER])
			micro_tick_divider_seen <= 1'b1;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i | st_tick[stw_pkg::ST_MICRO_TICK_DIVIDER] | ~tb_run)
			micro_tick_divider_gap <= 8'h01;
		else if (micro_tick_divider_gap != 8'hff)
			micro_tick_divider_gap <= micro_tick_divider_gap + 8'h01;
	end

	a_soft_reset_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(wr_soft_reset_request && reset_request_bit && !sfr_wdata_i[0]) |=> sys_reset_o ##1 !sys_reset_o)
		else $error("soft reset request did not pulse reset");

	a_prio_fixed_ones: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(sfr_rd_i && sfr_addr_i == 8'hf8) |=> (sfr_rdata_o[7:5] == 3'b111
			&& sfr_rdata_o[4:0] == prio_o))
		else $error("priority register read wrong");

	a_slow_read_clear: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(rd_slow && !st_tick[stw_pkg::ST_SLOW]) |=> !slow_irq_o)
		else $error("slow timer read did not clear pending flag");

	a_slow_irq_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		st_tick[stw_pkg::ST_SLOW] |=> slow_irq_o)
		else $error("slow timer tick lost");

	a_load_bit_zero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(rd_slow || rd_fast) |=> !sfr_rdata_o[7])
		else $error("load immediately bit read as one");

	a_micro_tick_divider_period: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_tick[stw_pkg::ST_MICRO_TICK_DIVIDER] && micro_tick_divider_seen && $stable(micro_tick_divisor) && $past(tb_run)
			&& micro_tick_divider_gap <= 8'h40)
		|-> (micro_tick_divider_gap == {2'h0, micro_tick_divisor} + 8'h01))
		else $error("microsecond tick period wrong");

	a_wd_enable_seq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(wd_en_fall && !watchdog_power_down_i) |=> (wd_state == stw_pkg::WD_RUN
			&& wd_cnt == {1'b0, $past(watchdog_control[4:0])} + 6'h01))
		else $error("watchdog enable sequence ignored");

	a_wd_disable_seq: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wd_dis_fall |=> wd_state == stw_pkg::WD_OFF)
		else $error("watchdog disable sequence ignored");

	a_wd_expiry_path: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		wd_expire |=> (sys_reset_o == $past(watchdog_reset_enable_i))
			&& (watchdog_irq_o != $past(watchdog_reset_enable_i)))
		else $error("watchdog expiry took wrong path");

	a_tb_power_down: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(timebase_power_down_i && $past(timebase_power_down_i))
		|-> !(st_tick[stw_pkg::ST_MICRO_TICK_DIVIDER] || st_tick[stw_pkg::ST_TICK_PRESCALE] || st_tick[stw_pkg::ST_SLOW]))
		else $error("timebase counted while powered down");

	a_wd_power_down: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		watchdog_power_down_i |=> wd_state == stw_pkg::WD_OFF
			##1 (wd_state == stw_pkg::WD_OFF && !watchdog_irq_o))
		else $error("watchdog ran while powered down");

endmodule : stw_timebase

// ---- sim/stw_timebase_test.sv ----
/*
 * stw_timebase_test: self-checking bench for the timebase and watchdog block.
 * assumes: hw/stw_pkg.sv, hw/stw_divider.sv and hw/stw_timebase.sv compile first.
 */
`timescale 1ns/1ps
module stw_timebase_test;
	logic clk_i, sys_rst_i, sfr_wr_i, sfr_rd_i;
	logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, d;
	logic timebase_power_down_i, watchdog_power_down_i, watchdog_reset_enable_i;
	stw_pkg::stw_ticks_t ticks_o;
	stw_pkg::stw_prio_t prio_o;
	logic slow_irq_o, fast_irq_o, watchdog_irq_o, sys_reset_o;
	int n_mismatch = 0;
	int n_compared = 0;
	int n;
	logic [7:0] exp_rst [10] = '{8'h03, 8'h00, 8'he0, 8'h7f, 8'h7f, 8'h03, 8'h9f, 8'h0f,
		8'h63, 8'h00};
	// one observable bit per event, indexed by the measuring tasks
	wire logic [8:0] obs = {ticks_o, slow_irq_o, fast_irq_o, watchdog_irq_o, sys_reset_o};

	stw_timebase u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .sfr_addr_i(sfr_addr_i),
		.sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i),
		.sfr_rdata_o(sfr_rdata_o), .timebase_power_down_i(timebase_power_down_i),
		.watchdog_power_down_i(watchdog_power_down_i),
		.watchdog_reset_enable_i(watchdog_reset_enable_i), .ticks_o(ticks_o),
		.slow_irq_o(slow_irq_o), .fast_irq_o(fast_irq_o), .watchdog_irq_o(watchdog_irq_o),
		.sys_reset_o(sys_reset_o), .prio_o(prio_o));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		// one idle edge so a strobe is never lowered and raised in one step
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_wdata_i = v;
		sfr_wr_i = 1'b1;
		@(negedge clk_i);
		sfr_wr_i = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(negedge clk_i);
		sfr_addr_i = a;
		sfr_rd_i = 1'b1;
		@(negedge clk_i);
		sfr_rd_i = 1'b0;
		v = sfr_rdata_o;
	endtask : rd

	// counts falling edges up to the next rise of obs[k]; reads ca while it is high if cl is set
	task automatic rise(input int k, input logic [7:0] ca, input bit cl, input int lim,
		output int cnt);
		logic p, c;
		cnt = 0;
		c = obs[k];
		do begin
			p = c;
			sfr_addr_i = ca;
			sfr_rd_i = cl & (c === 1'b1);
			@(negedge clk_i);
			c = obs[k];
			cnt++;
		end while (!(c === 1'b1 && p === 1'b0) && cnt < lim);
	endtask : rise

	task automatic gap(input string nm, input int k, input logic [7:0] ca, input bit cl,
		input int exp);
		int g;
		rise(k, ca, cl, 3000, g);
		rise(k, ca, cl, 3000, g);
		chk(nm, 16'(g), 16'(exp));
	endtask : gap

	task automatic stop_test;
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_values;
		for (int i = 0; i < 10; i++) begin
			rd(8'hf6 + 8'(i), d);
			chk("reset value", {8'h00, d}, {8'h00, exp_rst[i]});
		end
		rd(8'h10, d);
		chk("unmapped read", {8'h00, d}, 16'h0000);
	endtask : t_reset_values

	task automatic t_regs;
		wr(8'hf8, 8'h1f);
		rd(8'hf8, d);
		chk("prio read", {8'h00, d}, 16'h00ff);
		chk("prio out", {11'h000, prio_o}, 16'h001f);
		wr(8'hf8, 8'h10);
		chk("prio out", {11'h000, prio_o}, 16'h0010);
		wr(8'hf9, 8'hff);
		rd(8'hf9, d);
		chk("slow read", {8'h00, d}, 16'h007f);
		wr(8'hfa, 8'hff);
		rd(8'hfa, d);
		chk("fast read", {8'h00, d}, 16'h007f);
	endtask : t_regs

	task automatic t_soft_reset;
		logic s;
		wr(8'hf7, 8'h01);
		chk("reset early", {15'h0000, sys_reset_o}, 16'h0000);
		wr(8'hf7, 8'h00);
		s = sys_reset_o;
		@(negedge clk_i);
		s = s | sys_reset_o;
		chk("soft reset", {15'h0000, s}, 16'h0001);
	endtask : t_soft_reset

	// short divisors are loaded while the chain is stopped so no long count is pending
	task automatic t_ticks;
		wr(8'hfb, 8'h02);
		wr(8'hfc, 8'h04);
		wr(8'hfd, 8'h00);
		wr(8'hfe, 8'h01);
		wr(8'hf6, 8'h01);
		rise(8, 8'h00, 1'b0, 50, n);
		chk("stopped micro_tick_divider", 16'(n), 16'd50);
		timebase_power_down_i = 1'b0;
		gap("micro_tick_divider period", 8, 8'h00, 1'b0, 3);
		gap("tick_prescale period", 7, 8'h00, 1'b0, 5);
		gap("deci period", 6, 8'h00, 1'b0, 10);
		gap("adc period", 5, 8'h00, 1'b0, 2);
		gap("mod period", 4, 8'h00, 1'b0, 128);
	endtask : t_ticks

	task automatic t_timers;
		wr(8'hfa, 8'h82);
		gap("fast period", 2, 8'hfa, 1'b1, 15);
		wr(8'hfa, 8'h01);
		gap("fast reload", 2, 8'hfa, 1'b1, 10);
		wr(8'hf9, 8'h81);
		gap("slow period", 3, 8'hf9, 1'b1, 20);
	endtask : t_timers

	task automatic t_watchdog;
		wr(8'hff, 8'h82);
		wr(8'hff, 8'h02);
		rise(1, 8'h00, 1'b0, 100, n);
		chk("wd expiry", 16'(n >= 29 && n <= 42), 16'h0001);
		gap("wd period", 1, 8'h00, 1'b0, 30);
		watchdog_reset_enable_i = 1'b1;
		rise(0, 8'h00, 1'b0, 100, n);
		chk("wd reset", 16'(n < 40), 16'h0001);
		wr(8'hff, 8'h40);
		wr(8'hff, 8'h00);
		rise(0, 8'h00, 1'b0, 100, n);
		chk("wd disabled", 16'(n), 16'd100);
		wr(8'hff, 8'h82);
		wr(8'hff, 8'h02);
		for (int i = 0; i < 4; i++) begin
			repeat (20) @(negedge clk_i);
			wr(8'hff, 8'h22);
			wr(8'hff, 8'h02);
		end
		chk("wd restarted", {15'h0000, sys_reset_o}, 16'h0000);
		watchdog_power_down_i = 1'b1;
		rise(0, 8'h00, 1'b0, 100, n);
		chk("wd powered down", 16'(n), 16'd100);
	endtask : t_watchdog

	// ----------------------------------------------------------------
	// clock, watchdog and main sequence
	// ----------------------------------------------------------------
	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	initial begin
		#1000000;
		n_mismatch++;
		stop_test;
	end

	initial begin
		sys_rst_i = 1'b1;
		sfr_wr_i = 1'b0;
		sfr_rd_i = 1'b0;
		sfr_addr_i = 8'h00;
		sfr_wdata_i = 8'h00;
		timebase_power_down_i = 1'b1;
		watchdog_power_down_i = 1'b1;
		watchdog_reset_enable_i = 1'b0;
		repeat (10) @(negedge clk_i);
		sys_rst_i = 1'b0;
		watchdog_power_down_i = 1'b0;
		t_reset_values;
		t_regs;
		t_soft_reset;
		t_ticks;
		t_timers;
		t_watchdog;
		stop_test;
	end
endmodule : stw_timebase_test
